// File: brake_sup_pkg.sv
// Constants shared by the braking unit supervisor: register map, field
// positions, reset values and timing counts.
// Assumes a 10 MHz APB clock and 32-bit APB data.
package brake_sup_pkg;
    // Clock and cooling period
    localparam int unsigned CLK_FREQ_HZ    = 10_000_000;
    localparam int unsigned COOL_TIME_MS   = 1000;
    localparam int unsigned COOL_CYCLES    = (CLK_FREQ_HZ / 1000) * COOL_TIME_MS;

    // Data widths
    localparam int unsigned MEAS_W         = 16;
    localparam int unsigned RES_ID_W       = 8;
    localparam int unsigned FAULT_W        = 5;
    localparam int unsigned WARN_W         = 4;
    localparam int unsigned IRQ_W          = 8;

    // Register byte offsets
    localparam logic [7:0] STATUS_OFS      = 8'h00;
    localparam logic [7:0] TEMP_MAX_OFS    = 8'h04;
    localparam logic [7:0] I2T_MAX_OFS     = 8'h08;
    localparam logic [7:0] ENERGY_MAX_OFS  = 8'h0C;
    localparam logic [7:0] RES_ID_A_OFS    = 8'h10;
    localparam logic [7:0] RES_ID_B_OFS    = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFS  = 8'h18;
    localparam logic [7:0] IRQ_CLEAR_OFS   = 8'h1C;
    localparam logic [7:0] IRQ_ENABLE_OFS  = 8'h20;

    // Fault field positions
    localparam int unsigned F_NO_ENABLE    = 0;
    localparam int unsigned F_OVERTEMP     = 1;
    localparam int unsigned F_OVERCURRENT  = 2;
    localparam int unsigned F_I2T          = 3;
    localparam int unsigned F_GND_SHORT    = 4;

    // Prewarning field positions (status bits 8..11)
    localparam int unsigned WARN_POS       = 8;
    localparam int unsigned W_TEMP         = 0;
    localparam int unsigned W_I2T          = 1;
    localparam int unsigned W_ENERGY       = 2;
    localparam int unsigned W_BAD_RES      = 3;

    // Further status bits
    localparam int unsigned S_COOLING      = 12;
    localparam int unsigned S_INHIBIT      = 13;
    localparam int unsigned S_DISCHARGE    = 14;
    localparam int unsigned S_BRAKE_EN     = 15;

    // Interrupt field positions (faults occupy 0..4)
    localparam int unsigned I_PREWARN      = 5;
    localparam int unsigned I_ACK          = 6;
    localparam int unsigned I_COOL_DONE    = 7;

    // Reset values
    localparam logic [15:0] TEMP_MAX_RST   = 16'h0FA0;
    localparam logic [15:0] I2T_MAX_RST    = 16'hFFFF;
    localparam logic [15:0] ENERGY_MAX_RST = 16'hFFFF;
    localparam logic [7:0]  RES_ID_A_RST   = 8'h11; // Arbitrary value
    localparam logic [7:0]  RES_ID_B_RST   = 8'h22; // Arbitrary value
    localparam logic [7:0]  IRQ_ENABLE_RST = 8'h00;
endpackage : brake_sup_pkg

// File: brake_sync.sv
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs may change at any time relative to pclk.
`timescale 1ns/1ps
module brake_sync #(
    parameter int unsigned W = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First flop feeds only the second flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : brake_sync

// File: brake_supervisor.sv
// Supervisory and terminal logic of a DC-link braking unit with APB registers.
// Assumes measured values arrive as synchronous binary words from the
// measurement front end; terminal inputs are asynchronous.
//
// Notes on behaviour
// R1: Inhibit input low enables braking, high inhibits.
// R2: Inhibit falling edge clears acknowledgeable faults.
// R3: Manual input high switches resistor on directly.
// R4: Inhibit beats manual discharge when both high.
// R5: Prewarn output high idle, low on prewarning.
// R6: Ready output high when fault free, falls on fault.
// R7: Prewarn at temperature reaching 80 percent maximum.
// R8: Prewarn at I2t load reaching 80 percent.
// R9: Prewarn at braking energy reaching 80 percent.
// R10: Identify resistor; prewarn on unapproved type.
// R11: Short circuit and overload reported as faults.
// R12: Ground faults reported as faults.
// R13: Overtemperature acknowledge only after cooling period.
// R14: Controller uses quick discharge rarely, after mains off.
// R15: Quick discharge only when disconnected, motors stopped. Not checked here: discharge follows the manual input unless inhibited.
// R16: Synchronise inputs; acknowledge edge from synchronised signal.
// R17: Fault for missing enable, overtemp, overcurrent, I2t, ground.
`timescale 1ns/1ps
module brake_supervisor #(
    parameter int unsigned MW          = brake_sup_pkg::MEAS_W,
    parameter int unsigned IW          = brake_sup_pkg::RES_ID_W,
    parameter int unsigned COOL_CYCLES = brake_sup_pkg::COOL_CYCLES
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Terminal block
    input  wire logic          inhibit_ack_input,
    input  wire logic          manual_discharge_input,
    output logic               prewarn_output,
    output logic               ready_fault_output,
    // Monitoring front end
    input  wire logic [MW-1:0] temp_meas,
    input  wire logic [MW-1:0] i2t_meas,
    input  wire logic [MW-1:0] energy_meas,
    input  wire logic [IW-1:0] res_id,
    input  wire logic          res_id_valid,
    input  wire logic          short_det,
    input  wire logic          overload_det,
    input  wire logic          ground_det,
    // Power stage and interrupt
    output logic               brake_enable,
    output logic               discharge_on,
    output logic               irq
);
    localparam int unsigned FW = brake_sup_pkg::FAULT_W;
    localparam int unsigned WW = brake_sup_pkg::WARN_W;
    localparam int unsigned QW = brake_sup_pkg::IRQ_W;

    // Synchronised terminal inputs
    logic [1:0] term_s;
    logic       inh_s;
    logic       man_s;
    logic       inh_d_r;

    brake_sync #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({manual_discharge_input, inhibit_ack_input}),
        .q       (term_s)
    );                                                     // [R16]

    assign inh_s = term_s[0];
    assign man_s = term_s[1];

    // Configuration and state registers
    logic [MW-1:0] temp_max_r;
    logic [MW-1:0] i2t_max_r;
    logic [MW-1:0] energy_max_r;
    logic [IW-1:0] res_id_a_r;
    logic [IW-1:0] res_id_b_r;
    logic [QW-1:0] irq_en_r;
    logic [QW-1:0] irq_stat_r;
    logic [QW-1:0] irq_stat_nxt;
    logic [FW-1:0] fault_r;
    logic [FW-1:0] fault_nxt;
    logic [WW-1:0] warn_r;
    logic [31:0]   cool_cnt_r;
    logic [31:0]   cool_cnt_nxt;

    // APB decode
    wire        apb_access = psel & penable & ~pready;
    wire        apb_done   = psel & penable & pready;
    wire        wr_fire    = apb_done & pwrite & ~pslverr;
    wire        hit_status = (paddr == brake_sup_pkg::STATUS_OFS);
    wire        hit_tmax   = (paddr == brake_sup_pkg::TEMP_MAX_OFS);
    wire        hit_imax   = (paddr == brake_sup_pkg::I2T_MAX_OFS);
    wire        hit_emax   = (paddr == brake_sup_pkg::ENERGY_MAX_OFS);
    wire        hit_ida    = (paddr == brake_sup_pkg::RES_ID_A_OFS);
    wire        hit_idb    = (paddr == brake_sup_pkg::RES_ID_B_OFS);
    wire        hit_istat  = (paddr == brake_sup_pkg::IRQ_STATUS_OFS);
    wire        hit_iclr   = (paddr == brake_sup_pkg::IRQ_CLEAR_OFS);
    wire        hit_ien    = (paddr == brake_sup_pkg::IRQ_ENABLE_OFS);
    wire        mapped     = hit_status | hit_tmax | hit_imax | hit_emax | hit_ida | hit_idb
                           | hit_istat | hit_iclr | hit_ien;
    wire        ro_hit     = hit_status | hit_istat;
    wire        bad_access = ~mapped | (pwrite & ro_hit);

    // Threshold compares: 5*meas >= 4*max means meas reached 80 percent
    wire [MW+2:0] temp_x5   = {3'b000, temp_meas} + {1'b0, temp_meas, 2'b00};
    wire [MW+2:0] i2t_x5    = {3'b000, i2t_meas} + {1'b0, i2t_meas, 2'b00};
    wire [MW+2:0] energy_x5 = {3'b000, energy_meas} + {1'b0, energy_meas, 2'b00};
    wire          temp_warn   = temp_x5 >= {1'b0, temp_max_r, 2'b00};       // [R7]
    wire          i2t_warn    = i2t_x5 >= {1'b0, i2t_max_r, 2'b00};         // [R8]
    wire          energy_warn = energy_x5 >= {1'b0, energy_max_r, 2'b00};   // [R9]
    wire          res_ok      = (res_id == res_id_a_r) | (res_id == res_id_b_r);
    wire          bad_res     = res_id_valid & ~res_ok;                     // [R10]
    wire [WW-1:0] warn_now    = {bad_res, energy_warn, i2t_warn, temp_warn};

    // Fault causes
    wire [FW-1:0] fault_set;
    assign fault_set[brake_sup_pkg::F_NO_ENABLE]   = inh_s;                     // [R17]
    assign fault_set[brake_sup_pkg::F_OVERTEMP]    = temp_meas >= temp_max_r;   // [R17]
    assign fault_set[brake_sup_pkg::F_OVERCURRENT] = overload_det;              // [R11]
    assign fault_set[brake_sup_pkg::F_I2T]         = i2t_meas >= i2t_max_r;     // [R17]
    assign fault_set[brake_sup_pkg::F_GND_SHORT]   = short_det | ground_det;    // [R11] [R12]

    // Acknowledge on falling edge of the synchronised inhibit input
    wire          ack_edge  = inh_d_r & ~inh_s;                                 // [R2] [R16]
    wire          cooling   = cool_cnt_r != 32'h0000_0000;
    wire          ot_clr_ok = ~cooling & ~fault_set[brake_sup_pkg::F_OVERTEMP]; // [R13]
    wire [FW-1:0] ack_mask;

    // Overtemperature clears only after the cooling period has elapsed
    assign ack_mask = ack_edge ? (ot_clr_ok ? {FW{1'b1}}
                                            : ~(FW'(1) << brake_sup_pkg::F_OVERTEMP))
                               : {FW{1'b0}};                                    // [R13]

    // Set wins over acknowledge so no fault is lost
    assign fault_nxt = (fault_r & ~ack_mask) | fault_set;                      // [R2] [R17]

    // Cooling counter reloads while overtemperature is present
    assign cool_cnt_nxt = fault_set[brake_sup_pkg::F_OVERTEMP] ? 32'(COOL_CYCLES)
                        : cooling ? cool_cnt_r - 32'h0000_0001
                        : cool_cnt_r;                                           // [R13]

    // Interrupt events
    wire [QW-1:0] irq_event;
    wire [QW-1:0] irq_clr = (wr_fire & hit_iclr) ? pwdata[QW-1:0] : {QW{1'b0}};
    wire          warn_any_now = |warn_now;
    wire          warn_any_old = |warn_r;

    assign irq_event[FW-1:0] = fault_set & ~fault_r;
    assign irq_event[brake_sup_pkg::I_PREWARN]   = warn_any_now & ~warn_any_old;
    assign irq_event[brake_sup_pkg::I_ACK]       = ack_edge;
    assign irq_event[brake_sup_pkg::I_COOL_DONE] = (cool_cnt_r == 32'h0000_0001)
                                                 & ~fault_set[brake_sup_pkg::F_OVERTEMP];
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_event;

    // Output terms
    wire no_fault   = ~|fault_nxt;
    wire brake_nxt  = ~inh_s & no_fault;                                        // [R1]
    wire disch_nxt  = man_s & ~inh_s;                                           // [R3] [R4]
    wire irq_nxt    = |(irq_stat_nxt & irq_en_r);

    // Read mux
    wire [31:0] status_word = {16'h0000, brake_enable, discharge_on, inh_s, cooling,
                               warn_r, 3'b000, fault_r};
    wire [31:0] rd_data =
        hit_status ? status_word
      : hit_tmax   ? {{(32-MW){1'b0}}, temp_max_r}
      : hit_imax   ? {{(32-MW){1'b0}}, i2t_max_r}
      : hit_emax   ? {{(32-MW){1'b0}}, energy_max_r}
      : hit_ida    ? {{(32-IW){1'b0}}, res_id_a_r}
      : hit_idb    ? {{(32-IW){1'b0}}, res_id_b_r}
      : hit_istat  ? {{(32-QW){1'b0}}, irq_stat_r}
      : hit_ien    ? {{(32-QW){1'b0}}, irq_en_r}
      : 32'h0000_0000;

    // APB answer: one wait state, then pready for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= apb_access;
            pslverr <= apb_access & bad_access;
            prdata  <= (apb_access & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_max_r   <= MW'(brake_sup_pkg::TEMP_MAX_RST);
            i2t_max_r    <= MW'(brake_sup_pkg::I2T_MAX_RST);
            energy_max_r <= MW'(brake_sup_pkg::ENERGY_MAX_RST);
            res_id_a_r   <= IW'(brake_sup_pkg::RES_ID_A_RST);
            res_id_b_r   <= IW'(brake_sup_pkg::RES_ID_B_RST);
            irq_en_r     <= brake_sup_pkg::IRQ_ENABLE_RST;
        end else if (ce && wr_fire) begin
            if (hit_tmax) temp_max_r <= pwdata[MW-1:0];
            if (hit_imax) i2t_max_r <= pwdata[MW-1:0];
            if (hit_emax) energy_max_r <= pwdata[MW-1:0];
            if (hit_ida) res_id_a_r <= pwdata[IW-1:0];
            if (hit_idb) res_id_b_r <= pwdata[IW-1:0];
            if (hit_ien) irq_en_r <= pwdata[QW-1:0];
        end
    end

    // Supervision state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_d_r    <= 1'b0;
            fault_r    <= '0;
            warn_r     <= '0;
            cool_cnt_r <= 32'h0000_0000;
            irq_stat_r <= '0;
        end else if (ce) begin
            inh_d_r    <= inh_s;
            fault_r    <= fault_nxt;
            warn_r     <= warn_now;
            cool_cnt_r <= cool_cnt_nxt;
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // Registered terminal and power-stage outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prewarn_output     <= 1'b1;
            ready_fault_output <= 1'b0;
            brake_enable       <= 1'b0;
            discharge_on       <= 1'b0;
            irq                <= 1'b0;
        end else if (ce) begin
            prewarn_output     <= ~warn_any_now;  // [R5]
            ready_fault_output <= no_fault;       // [R6]
            brake_enable       <= brake_nxt;      // [R1]
            discharge_on       <= disch_nxt;      // [R3] [R4]
            irq                <= irq_nxt;
        end
    end
endmodule : brake_supervisor

// File: ctrl_model.sv
// Model of the drive controller that works the two control terminals.
// Assumes requests come from the bench in the pclk domain.
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic pclk,
    input  wire logic inh_req,
    input  wire logic dis_req,
    output logic      inhibit_ack_input = 1'b0,
    output logic      manual_discharge_input = 1'b0
);
    // Terminals follow requests one edge later; every discharge request is passed on, and mains and motors are not modelled
    always @(posedge pclk) begin
        inhibit_ack_input      <= inh_req;
        manual_discharge_input <= dis_req;
    end
endmodule : ctrl_model

// File: brake_supervisor_monitor.sv
// Checker for the terminal and monitoring behaviour of the supervisor.
// Assumes limit and resistor id registers keep their reset values.
`timescale 1ns/1ps
module brake_supervisor_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        inhibit_ack_input,
    input wire logic        manual_discharge_input,
    input wire logic        prewarn_output,
    input wire logic        ready_fault_output,
    input wire logic [15:0] temp_meas,
    input wire logic [15:0] i2t_meas,
    input wire logic [15:0] energy_meas,
    input wire logic [7:0]  res_id,
    input wire logic        res_id_valid,
    input wire logic        short_det,
    input wire logic        overload_det,
    input wire logic        ground_det,
    input wire logic        brake_enable,
    input wire logic        discharge_on,
    input wire logic        irq
);
    // Prewarn thresholds at 80 percent of the reset limits
    localparam int unsigned TW = (4 * brake_sup_pkg::TEMP_MAX_RST) / 5;
    localparam int unsigned LW = (4 * brake_sup_pkg::I2T_MAX_RST) / 5;
    localparam int unsigned EW = (4 * brake_sup_pkg::ENERGY_MAX_RST) / 5;
    logic [2:0] up_r;
    // Counts the first edges after reset so delayed samples are valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h4) begin
            up_r <= up_r + 3'h1;
        end
    end
    wire logic up = (up_r == 3'h4);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_discharge_follow:
        assert property (up |-> discharge_on == ($past(manual_discharge_input, 3) && !$past(inhibit_ack_input, 3)))
        else $error("discharge output does not follow manual input");
    a_inhibit_wins:
        assert property (up && $past(inhibit_ack_input, 3) |-> !discharge_on && !brake_enable)
        else $error("resistor or braking active while inhibited");
    a_no_enable_fault:
        assert property (up && $past(inhibit_ack_input, 3) |-> !ready_fault_output)
        else $error("ready high while inhibited");
    a_brake_needs_ready:
        assert property (brake_enable |-> ready_fault_output)
        else $error("braking enabled while faulted");
    a_short_trip:
        assert property (short_det || overload_det |=> !ready_fault_output)
        else $error("short or overload not reported");
    a_ground_trip:
        assert property (ground_det |=> !ready_fault_output)
        else $error("ground fault not reported");
    a_temp_warn:
        assert property (temp_meas >= TW |=> !prewarn_output)
        else $error("temperature prewarning missing");
    a_load_warn:
        assert property (i2t_meas >= LW |=> !prewarn_output)
        else $error("load factor prewarning missing");
    a_energy_warn:
        assert property (energy_meas >= EW |=> !prewarn_output)
        else $error("energy prewarning missing");
    a_bad_resistor:
        assert property (res_id_valid && res_id != brake_sup_pkg::RES_ID_A_RST
                         && res_id != brake_sup_pkg::RES_ID_B_RST |=> !prewarn_output)
        else $error("unapproved resistor not warned");
    a_warn_idle:
        assert property (temp_meas < TW && i2t_meas < LW && energy_meas < EW && !res_id_valid |=> prewarn_output)
        else $error("prewarning without cause");
    // Main scenarios reached
    c_discharge: cover property (discharge_on);
    c_irq: cover property (irq);
    c_fault: cover property ($fell(ready_fault_output));
endmodule : brake_supervisor_monitor
bind brake_supervisor brake_supervisor_monitor mon_u (.pclk(pclk), .presetn(presetn),
    .inhibit_ack_input(inhibit_ack_input), .manual_discharge_input(manual_discharge_input),
    .prewarn_output(prewarn_output), .ready_fault_output(ready_fault_output), .temp_meas(temp_meas),
    .i2t_meas(i2t_meas), .energy_meas(energy_meas), .res_id(res_id), .res_id_valid(res_id_valid),
    .short_det(short_det), .overload_det(overload_det), .ground_det(ground_det),
    .brake_enable(brake_enable), .discharge_on(discharge_on), .irq(irq));

// File: brake_supervisor_bench.sv
// Self-checking bench for the braking unit supervisor.
// Assumes cooling shortened to 20 cycles and limit registers left at reset.
`timescale 1ns/1ps
module brake_supervisor_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, inh, man;
    logic        inh_req = 1'b0, dis_req = 1'b0, rvalid = 1'b0;
    logic        prewarn_output, ready_fault_output, brake_enable, discharge_on, irq;
    logic [15:0] temp = 16'h0, i2t = 16'h0, energy = 16'h0;
    logic [7:0]  rid = 8'h00;
    logic [2:0]  det = 3'h0;
    int          fails = 0, compares = 0;
    logic [7:0]  adr [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    logic [31:0] rst [6] = '{32'h0FA0, 32'hFFFF, 32'hFFFF, 32'h11, 32'h22, 32'h0};
    initial forever #50 pclk = ~pclk;
    brake_supervisor #(.COOL_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inhibit_ack_input(inh), .manual_discharge_input(man), .prewarn_output(prewarn_output),
        .ready_fault_output(ready_fault_output), .temp_meas(temp), .i2t_meas(i2t), .energy_meas(energy),
        .res_id(rid), .res_id_valid(rvalid), .short_det(det[0]), .overload_det(det[1]), .ground_det(det[2]),
        .brake_enable(brake_enable), .discharge_on(discharge_on), .irq(irq));
    ctrl_model ctrl_u (.pclk(pclk), .inh_req(inh_req), .dis_req(dis_req), .inhibit_ack_input(inh),
        .manual_discharge_input(man));
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // Compares and counts
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Inhibit pulse whose falling edge acknowledges
    task automatic ack;
        @(posedge pclk);
        inh_req <= 1'b1;
        tick(5);
        inh_req <= 1'b0;
        tick(7);
        @(negedge pclk);
    endtask : ack
    // One prewarn cause at or just below its threshold
    task automatic put(input int k, input logic [15:0] b);
        temp   <= (k == 0) ? 16'h0C80 - b : 16'h0000;
        i2t    <= (k == 1) ? 16'hCCCC - b : 16'h0000;
        energy <= (k == 2) ? 16'hCCCC - b : 16'h0000;
        rid    <= (b != 16'h0) ? brake_sup_pkg::RES_ID_B_RST : 8'h33;
        rvalid <= (k == 3);
    endtask : put
    task automatic close_out;
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    initial begin
        tick(20000);
        fails++;
        close_out();
    end
    initial begin
        tick(16);
        presetn <= 1'b1;
        // Reset values, then refused accesses
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, adr[k], 32'h0);
            chk("reset value", rd, rst[k]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'b1, brake_sup_pkg::STATUS_OFS, 32'hFFFF);
        chk("read-only error", 32'(err), 32'h1);
        @(negedge pclk);
        chk("ready", 32'(ready_fault_output), 32'h1);
        // Quick discharge, then inhibit overriding it
        tick(1);
        dis_req <= 1'b1;
        tick(5);
        @(negedge pclk);
        chk("discharge", 32'(discharge_on), 32'h1);
        chk("brake enable", 32'(brake_enable), 32'h1);
        tick(1);
        inh_req <= 1'b1;
        tick(5);
        @(negedge pclk);
        chk("discharge inhibited", 32'(discharge_on), 32'h0);
        chk("brake inhibited", 32'(brake_enable), 32'h0);
        chk("no enable fault", 32'(ready_fault_output), 32'h0);
        tick(1);
        dis_req <= 1'b0;
        inh_req <= 1'b0;
        tick(7);
        @(negedge pclk);
        chk("ready after release", 32'(ready_fault_output), 32'h1);
        // Each detector trips a sticky fault that an acknowledge clears
        for (int k = 0; k < 3; k++) begin
            tick(1);
            det <= 3'(1 << k);
            tick(1);
            det <= 3'h0;
            tick(3);
            @(negedge pclk);
            chk("fault ready", 32'(ready_fault_output), 32'h0);
            ack();
            chk("ack ready", 32'(ready_fault_output), 32'h1);
        end
        // Prewarn causes at threshold and one below
        for (int k = 0; k < 4; k++) begin
            for (int b = 0; b < 2; b++) begin
                tick(1);
                put(k, 16'(b));
                tick(3);
                @(negedge pclk);
                chk("prewarn", 32'(prewarn_output), 32'(b));
            end
        end
        // Overtemperature: masked, enabled, held through cooling, then cleared
        tick(1);
        rvalid <= 1'b0;
        temp   <= brake_sup_pkg::TEMP_MAX_RST;
        tick(3);
        @(negedge pclk);
        chk("overtemp fault", 32'(ready_fault_output), 32'h0);
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, brake_sup_pkg::IRQ_ENABLE_OFS, 32'h2);
        apb(1'b0, brake_sup_pkg::IRQ_ENABLE_OFS, 32'h0);
        chk("irq enable", rd, 32'h2);
        @(negedge pclk);
        chk("irq raised", 32'(irq), 32'h1);
        tick(1);
        temp <= 16'h0;
        ack();
        chk("cooling hold", 32'(ready_fault_output), 32'h0);
        tick(25);
        ack();
        chk("cooled ack", 32'(ready_fault_output), 32'h1);
        apb(1'b1, brake_sup_pkg::IRQ_CLEAR_OFS, 32'hFF);
        apb(1'b0, brake_sup_pkg::IRQ_STATUS_OFS, 32'h0);
        chk("irq status", rd, 32'h0);
        @(negedge pclk);
        chk("irq cleared", 32'(irq), 32'h0);
        close_out();
    end
endmodule : brake_supervisor_bench
